// >>> inc/dbl_pkg.sv
// Shared constants and types for the double-buffered converter latch host.
// Assumes a single 50 MHz core clock domain.
package dbl_pkg;
   localparam int DATA_W = 16;
   localparam int CLK_PERIOD_NS = 20;
   // Least gap between first-rank latch and second-rank load
   localparam int RANK_GAP_NS = 100;
   localparam int RANK_GAP_CYC = (RANK_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Least strobe low and high widths (plain defaults)
   localparam int STROBE_NS = 60;
   localparam int STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int DATA_TOP_BIT = 15;
   localparam int CNT_W = 8;
   localparam logic [CNT_W-1:0] GAP_LOAD = CNT_W'(RANK_GAP_CYC);
   localparam logic [CNT_W-1:0] STROBE_LOAD = CNT_W'(STROBE_CYC);
   localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
   localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;
   localparam logic [DATA_W-1:0] DATA_RESET = 16'h0000;

   typedef enum logic [2:0] {
      DBL_IDLE = 3'b000,
      DBL_SETUP = 3'b001,
      DBL_WRITE = 3'b010,
      DBL_HOLD = 3'b011,
      DBL_GAP = 3'b100,
      DBL_UPDATE = 3'b101
   } dbl_state_t;

   // Pins toward the device
   typedef struct packed {
      logic select_n;
      logic first_rank_load_n;
      logic converter_update_strobe;
      logic [DATA_W-1:0] data;
   } dbl_pins_t;

   // User request
   typedef struct packed {
      logic valid;
      logic update;
      logic twos_comp;
      logic [DATA_W-1:0] sample;
   } dbl_req_t;
endpackage

// >>> hdl/dbl_host.sv
// Host controller that drives a double-buffered 16-bit converter input latch.
// Assumes the device pins are plain outputs on the core clock; no readback.
// Overview of operation
// - Multi-device update: load each first rank, then raise shared strobe.
// - Leave at least 100 ns between first-rank latch and update.
// - Tied strobe low plus high time must cover output settling.
// - Twos-complement samples get their top data bit inverted.
// - Idle strobes park at defined levels, never left floating.
`timescale 1ns/10ps
module dbl_host (
   input wire logic core_clk,
   input wire logic reset,
   input dbl_pkg::dbl_req_t req,
   output logic req_ready,
   output logic update_done,
   output dbl_pkg::dbl_pins_t pins
);
   import dbl_pkg::*;

   // ==========================================
   // Declarations
   // Sequencer group: phase, phase counter and the update choice
   dbl_state_t state_q, state_d;
   logic [CNT_W-1:0] cnt_q, cnt_d;
   logic upd_q, upd_d;
   // Pin group: everything the device sees
   logic [DATA_W-1:0] data_q, data_d;
   logic sel_n_q, sel_n_d;
   logic load_n_q, load_n_d;
   logic strobe_q, strobe_d;
   // Handshake group toward the user side
   logic ready_q, ready_d;
   logic done_q, done_d;
   // Phase events shared by the three groups
   logic take;
   logic write_end;
   logic gap_end;
   logic update_end;

   // ==========================================
   // Helpers
   function automatic logic [DATA_W-1:0] code_of(input logic [DATA_W-1:0] s, input logic tc);
      logic [DATA_W-1:0] r;
      r = s;
      r[DATA_TOP_BIT] = s[DATA_TOP_BIT] ^ tc;
      return r;
   endfunction

   // A phase ends on a count of one, so a load of N gives N cycles
   function automatic logic phase_over(input logic [CNT_W-1:0] c);
      return c <= CNT_ONE;
   endfunction

   // ==========================================
   // Phase events
   always_comb begin
      take = 1'b0;
      write_end = 1'b0;
      gap_end = 1'b0;
      update_end = 1'b0;
      case (state_q)
         DBL_IDLE: begin
            take = req.valid && ready_q;
         end
         DBL_WRITE: begin
            write_end = phase_over(cnt_q);
         end
         DBL_GAP: begin
            gap_end = phase_over(cnt_q);
         end
         DBL_UPDATE: begin
            update_end = phase_over(cnt_q);
         end
         default: begin
            take = 1'b0;
         end
      endcase
   end

   // ==========================================
   // Sequencer
   always_comb begin
      state_d = state_q;
      cnt_d = cnt_q;
      upd_d = upd_q;
      case (state_q)
         DBL_IDLE: begin
            if (take) begin
               upd_d = req.update;
               cnt_d = STROBE_LOAD;
               state_d = DBL_SETUP;
            end
         end
         DBL_SETUP: begin
            cnt_d = STROBE_LOAD;
            state_d = DBL_WRITE;
         end
         DBL_WRITE: begin
            if (write_end) begin
               cnt_d = STROBE_LOAD;
               state_d = DBL_HOLD;
            end else begin
               cnt_d = cnt_q - CNT_ONE;
            end
         end
         DBL_HOLD: begin
            if (upd_q) begin
               cnt_d = GAP_LOAD;
               state_d = DBL_GAP;
            end else begin
               state_d = DBL_IDLE;
            end
         end
         DBL_GAP: begin
            if (gap_end) begin
               cnt_d = STROBE_LOAD;
               state_d = DBL_UPDATE;
            end else begin
               cnt_d = cnt_q - CNT_ONE;
            end
         end
         DBL_UPDATE: begin
            if (update_end) begin
               cnt_d = CNT_ZERO;
               state_d = DBL_IDLE;
            end else begin
               cnt_d = cnt_q - CNT_ONE;
            end
         end
         default: begin
            cnt_d = CNT_ZERO;
            state_d = DBL_IDLE;
         end
      endcase
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         state_q <= DBL_IDLE;
         cnt_q <= CNT_ZERO;
         upd_q <= 1'b0;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         upd_q <= upd_d;
      end
   end

   // ==========================================
   // Device pins
   always_comb begin
      data_d = data_q;
      sel_n_d = sel_n_q;
      load_n_d = load_n_q;
      strobe_d = strobe_q;
      case (state_q)
         DBL_IDLE: begin
            if (take) begin
               data_d = code_of(req.sample, req.twos_comp);
            end
         end
         DBL_SETUP: begin
            sel_n_d = 1'b0;
            load_n_d = 1'b0;
         end
         DBL_WRITE: begin
            if (write_end) begin
               load_n_d = 1'b1;
            end
         end
         DBL_HOLD: begin
            // Select rises a cycle after the load strobe so data hold is met
            sel_n_d = 1'b1;
         end
         DBL_GAP: begin
            if (gap_end) begin
               strobe_d = 1'b1;
            end
         end
         DBL_UPDATE: begin
            if (update_end) begin
               strobe_d = 1'b0;
            end
         end
         default: begin
            sel_n_d = 1'b1;
            load_n_d = 1'b1;
            strobe_d = 1'b0;
         end
      endcase
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         data_q <= DATA_RESET;
         sel_n_q <= 1'b1;
         load_n_q <= 1'b1;
         strobe_q <= 1'b0;
      end else begin
         data_q <= data_d;
         sel_n_q <= sel_n_d;
         load_n_q <= load_n_d;
         strobe_q <= strobe_d;
      end
   end

   // ==========================================
   // Handshake
   always_comb begin
      ready_d = 1'b0;
      done_d = 1'b0;
      case (state_q)
         DBL_IDLE: begin
            // Ready drops on the take edge so one word is one transfer
            ready_d = !take;
         end
         DBL_HOLD: begin
            done_d = !upd_q;
         end
         DBL_UPDATE: begin
            done_d = update_end;
         end
         default: begin
            ready_d = 1'b0;
         end
      endcase
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         ready_q <= 1'b0;
         done_q <= 1'b0;
      end else begin
         ready_q <= ready_d;
         done_q <= done_d;
      end
   end

   // ==========================================
   // Outputs, all straight from flip-flops
   assign req_ready = ready_q;
   assign update_done = done_q;
   assign pins = '{select_n: sel_n_q, first_rank_load_n: load_n_q,
      converter_update_strobe: strobe_q, data: data_q};
endmodule

// >>> verif/dbl_host_sva.sv
// Checker for the converter latch host pins.
// Assumes the dbl_host top ports and one clock domain.
`timescale 1ns/10ps
module dbl_host_chk (
   input wire logic core_clk,
   input wire logic reset,
   input dbl_pkg::dbl_req_t req,
   input wire logic req_ready,
   input wire logic update_done,
   input dbl_pkg::dbl_pins_t pins
);
   import dbl_pkg::*;
   // ==========
   // Pin checks
   default clocking @(posedge core_clk); endclocking
   default disable iff (reset);
   update_gap_a: assert property ($rose(pins.converter_update_strobe)
      |-> $past(pins.first_rank_load_n, 5))
      else $error("update strobe too soon after load");
   update_alone_a: assert property (pins.converter_update_strobe
      |-> pins.select_n && pins.first_rank_load_n)
      else $error("update strobe during first rank load");
   strobe_width_a: assert property ($rose(pins.converter_update_strobe)
      |-> pins.converter_update_strobe[*3] ##1 !pins.converter_update_strobe && update_done)
      else $error("update strobe width wrong");
   top_invert_a: assert property (req.valid && req_ready
      |=> pins.data === ($past(req.sample) ^ {$past(req.twos_comp), 15'h0000}))
      else $error("data pins do not match sample");
   idle_park_a: assert property (req_ready
      |-> pins.select_n && pins.first_rank_load_n && !pins.converter_update_strobe)
      else $error("strobes not parked while idle");
   load_stable_a: assert property (!pins.first_rank_load_n |-> $stable(pins.data))
      else $error("data moved during first rank load");
endmodule
bind dbl_host dbl_host_chk chk_u (.core_clk(core_clk), .reset(reset), .req(req), .req_ready(req_ready),
   .update_done(update_done), .pins(pins));

// >>> verif/dbl_dev_model.sv
// Device model: two latch ranks behind the host pins.
// Assumes the pins come straight from dbl_host.
`timescale 1ns/10ps
module dbl_dev_model (
   input dbl_pkg::dbl_pins_t pins,
   output logic [dbl_pkg::DATA_W-1:0] first_rank,
   output logic [dbl_pkg::DATA_W-1:0] code
);
   import dbl_pkg::*;
   // ==========
   // Latch ranks
   // First rank latch
   always_latch if (!pins.select_n && !pins.first_rank_load_n) first_rank <= pins.data;
   always_latch if (pins.converter_update_strobe) code <= first_rank;
endmodule

// >>> verif/dbl_host_tb.sv
// Bench for the converter latch host with a device latch model.
// Assumes dbl_pkg, dbl_host, its checker and dbl_dev_model come first.
`timescale 1ns/10ps
module dbl_host_tb;
   import dbl_pkg::*;
   logic core_clk, reset, req_ready, update_done;
   dbl_req_t req;
   dbl_pins_t pins;
   logic [DATA_W-1:0] fr, code;
   int n_fail = 0;
   int comparisons = 0;
   dbl_host dut_u (.core_clk(core_clk), .reset(reset), .req(req), .req_ready(req_ready),
      .update_done(update_done), .pins(pins));
   dbl_dev_model dev_u (.pins(pins), .first_rank(fr), .code(code));
   // ==========
   // Tasks
   initial begin
      core_clk = 0;
      forever #10 core_clk = ~core_clk;
   end
   task automatic check(string what, logic [DATA_W-1:0] exp, logic [DATA_W-1:0] got);
      comparisons++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // Bounded waits: a hang shows up as a failed done check
   task automatic xfer(logic [DATA_W-1:0] s, logic tc, logic up);
      int n;
      for (n = 0; n < 40 && req_ready !== 1'b1; n++) @(negedge core_clk);
      req = '{1'b1, up, tc, s};
      @(negedge core_clk);
      req.valid = 1'b0;
      for (n = 0; n < 40 && update_done !== 1'b1; n++) @(negedge core_clk);
      check("done", 16'h0001, {15'h0000, update_done});
      @(negedge core_clk);
   endtask
   task automatic t_update();
      xfer(16'h0000, 1'b0, 1'b1);
      check("code zero", 16'h0000, code);
      xfer(16'hffff, 1'b0, 1'b1);
      check("code full", 16'hffff, code);
      $display("t_update done");
   endtask
   task automatic t_load_only();
      xfer(16'h1234, 1'b0, 1'b0);
      check("first rank", 16'h1234, fr);
      check("code held", 16'hffff, code);
      $display("t_load_only done");
   endtask
   task automatic t_twos();
      xfer(16'h0000, 1'b1, 1'b1);
      check("twos zero", 16'h8000, code);
      xfer(16'h7fff, 1'b1, 1'b1);
      check("twos max", 16'hffff, code);
      $display("t_twos done");
   endtask
   // Mid-run reset while idle: pins park, ready returns, second rank untouched
   task automatic t_reset();
      logic [2:0] park;
      reset = 1'b1;
      @(negedge core_clk);
      park = {pins.select_n, pins.first_rank_load_n, pins.converter_update_strobe};
      check("parked strobes", 16'h0006, {13'h0000, park});
      check("reset data", DATA_RESET, pins.data);
      check("ready in reset", 16'h0000, {15'h0000, req_ready});
      reset = 1'b0;
      @(negedge core_clk);
      check("ready after reset", 16'h0001, {15'h0000, req_ready});
      check("code kept", 16'hffff, code);
      xfer(16'h8000, 1'b0, 1'b1);
      check("bipolar zero", 16'h8000, code);
      $display("t_reset done");
   endtask
   // ==========
   // Main sequence and watchdog
   initial begin
      reset = 1'b1;
      req = '0;
      repeat (4) @(negedge core_clk);
      reset = 1'b0;
      t_update();
      t_load_only();
      t_twos();
      t_reset();
      end_sim();
   end
   initial begin
      #20000;
      n_fail++;
      end_sim();
   end
endmodule
